// *** hdl/elm_pkg.sv ***
// elm_pkg: constants and types shared by both ends of the lane mapper
// assumes: one core clock, 64-bit bus data, 32-bit word view of memory
package elm_pkg;
    // access sizes seen by the core load/store path
    typedef enum logic [1:0] {
        ELM_SZ_BYTE,
        ELM_SZ_HALF,
        ELM_SZ_WORD,
        ELM_SZ_DWORD
    } elm_size_t;
    // endian modes
    localparam logic ELM_LITTLE = 1'b0;
    localparam logic ELM_BIG = 1'b1;
    // widths
    localparam int ELM_AW = 32;
    localparam int ELM_DW = 64;
    localparam int ELM_WW = 32;
    localparam int ELM_BEW = 8;
    // byte lane within word flip for the other order
    localparam logic [1:0] ELM_BYTE_FLIP = 2'h3;
    // address bit that picks a word of a double word
    localparam int ELM_WSEL_BIT = 2;
    // lane index of the last byte of a word
    localparam logic [2:0] ELM_LAST_BYTE = 3'h3;
    localparam logic [2:0] ELM_WORD_LANES = 3'h4;
    // reset values
    localparam logic [63:0] ELM_DATA_RST = 64'h0;
    localparam logic [7:0] ELM_BE_RST = 8'h0;
endpackage

// *** hdl/elm_bus_if.sv ***
// elm_bus_if: 64-bit initiator to interconnect link of the lane mapper
// assumes: single clock domain, one request per cycle, in-order answers
`timescale 1ns/1ns
`default_nettype none
interface elm_bus_if;
    logic req; // request valid
    logic gnt; // request taken by target
    logic wr; // write when high
    logic [31:0] addr; // byte address, dword aligned
    logic [7:0] be; // byte lane enables
    logic [63:0] wdata; // write data on lanes
    logic big; // endianness of the access
    logic rvalid; // read answer valid
    logic [63:0] rdata; // read data on lanes
    // core side mapper end
    modport init (output req, wr, addr, be, wdata, big,
                  input gnt, rvalid, rdata);
    // interconnect / target end
    modport targ (input req, wr, addr, be, wdata, big,
                  output gnt, rvalid, rdata);
endinterface
`default_nettype wire

// *** hdl/elm_mapper.sv ***
// elm_mapper: maps core byte/half/word/dword accesses onto 64-bit lanes
// assumes: core holds a request until ack; one read outstanding at a time
//
// Function
// R01: memory is array of 32-bit words
// R02: little mode byte at 8*(s mod 4)
// R03: big mode byte at 8*(3-s mod 4)
// R04: half word is two mapped bytes
// R05: little byte i equals big i^3
// R06: whole words read same both modes
// R07: 64-bit port lanes depend on mode
// R08: little mode word at 32*(s mod 2)
// R09: big mode word at 32*(1-s mod 2)
// R10: interconnect honours access endianness
// R11: size converters set for system endianness
// R12: converters pick half by bit 2
// R13: mode sampled by clock, held per access
`timescale 1ns/1ns
`default_nettype none
module elm_mapper (
    input wire logic clk,
    input wire logic rstn,
    input wire logic big_mode,
    input wire logic core_req,
    input wire logic core_wr,
    input wire elm_pkg::elm_size_t core_size,
    input wire logic [31:0] core_addr,
    input wire logic [63:0] core_wdata,
    output logic core_ack,
    output logic core_rvalid,
    output logic [63:0] core_rdata,
    elm_bus_if.init bus
);
    typedef enum logic [1:0] {ELM_IDLE, ELM_REQ, ELM_WAIT} elm_state_t;

    elm_state_t state_r, state_nxt; // access sequencer
    logic mode_r, mode_nxt; // mode held for access in flight
    logic [2:0] off_r, off_nxt; // byte offset in dword
    elm_pkg::elm_size_t size_r, size_nxt; // size held for read return
    logic [31:0] addr_r, addr_nxt;
    logic [7:0] be_r, be_nxt;
    logic [63:0] wdata_r, wdata_nxt;
    logic wr_r, wr_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [63:0] rdata_r, rdata_nxt;
    logic [7:0] lane_be; // lanes for new request
    logic [63:0] lane_wd; // write data for new request
    logic [63:0] ret_d; // read data back to core order

    // physical lane of a logical byte offset within the dword
    function automatic logic [2:0] lane_of(input logic [2:0] off,
                                           input logic big);
        logic [2:0] l;
        l = off;
        if (big)
        begin
            // R09: big word slot flipped
            l[2] = ~off[2];
            // R03: big byte order
            l[1:0] = off[1:0] ^ elm_pkg::ELM_BYTE_FLIP;
        end
        // R02: little lane identity
        // R08: little word slot
        return l;
    endfunction

    // number of bytes an access covers
    function automatic logic [3:0] nbytes(input elm_pkg::elm_size_t s);
        case (s)
            elm_pkg::ELM_SZ_BYTE: nbytes = 4'h1;
            elm_pkg::ELM_SZ_HALF: nbytes = 4'h2;
            elm_pkg::ELM_SZ_WORD: nbytes = 4'h4;
            default: nbytes = 4'h8;
        endcase
    endfunction

    // scatter core bytes into lanes; core byte k is memory byte off+k, off+n-1-k in big mode
    always_comb
    begin
        logic [3:0] n;
        logic [2:0] o;
        logic [2:0] ln;
        o = 3'h0;
        ln = 3'h0;
        n = nbytes(core_size);
        lane_be = elm_pkg::ELM_BE_RST;
        lane_wd = elm_pkg::ELM_DATA_RST;
        for (int k = 0; k < 8; k++)
        begin
            // R04: half word as byte pairs
            // R01: bytes of 32-bit words
            o = core_addr[2:0] + 3'(k);
            ln = lane_of(o, big_mode);
            if (4'(k) < n)
            begin
                lane_be[ln] = 1'b1;
                // R06: word value kept whole
                if (big_mode && n > 4'h1)
                begin
                    // big core keeps msb at lowest address
                    lane_wd[ln*8 +: 8] =
                        core_wdata[(32'(n) - 1 - k)*8 +: 8];
                end
                else
                begin
                    lane_wd[ln*8 +: 8] = core_wdata[k*8 +: 8];
                end
            end
        end
    end

    // gather read lanes back into core order, right aligned
    always_comb
    begin
        logic [3:0] n;
        logic [2:0] o;
        logic [2:0] ln;
        o = 3'h0;
        ln = 3'h0;
        n = nbytes(size_r);
        ret_d = elm_pkg::ELM_DATA_RST;
        for (int k = 0; k < 8; k++)
        begin
            o = off_r + 3'(k);
            // R05: same physical byte, xor view
            ln = lane_of(o, mode_r);
            if (4'(k) < n)
            begin
                if (mode_r && n > 4'h1)
                begin
                    ret_d[(32'(n) - 1 - k)*8 +: 8] = bus.rdata[ln*8 +: 8];
                end
                else
                begin
                    ret_d[k*8 +: 8] = bus.rdata[ln*8 +: 8];
                end
            end
        end
    end

    // sequencer next state
    always_comb
    begin
        state_nxt = state_r;
        mode_nxt = mode_r;
        off_nxt = off_r;
        size_nxt = size_r;
        addr_nxt = addr_r;
        be_nxt = be_r;
        wdata_nxt = wdata_r;
        wr_nxt = wr_r;
        rvalid_nxt = 1'b0;
        rdata_nxt = rdata_r;
        case (state_r)
            ELM_IDLE:
            begin
                if (core_req)
                begin
                    // R13: mode captured per access
                    mode_nxt = big_mode;
                    off_nxt = core_addr[2:0];
                    size_nxt = core_size;
                    addr_nxt = {core_addr[31:3], 3'h0};
                    be_nxt = lane_be;
                    wdata_nxt = lane_wd;
                    wr_nxt = core_wr;
                    state_nxt = ELM_REQ;
                end
            end
            ELM_REQ:
            begin
                // request held until granted
                if (bus.gnt)
                begin
                    state_nxt = wr_r ? ELM_IDLE : ELM_WAIT;
                end
            end
            ELM_WAIT:
            begin
                if (bus.rvalid)
                begin
                    rdata_nxt = ret_d;
                    rvalid_nxt = 1'b1;
                    state_nxt = ELM_IDLE;
                end
            end
            default: state_nxt = ELM_IDLE;
        endcase
    end

    // sequencer registers
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            state_r <= ELM_IDLE;
            mode_r <= elm_pkg::ELM_LITTLE;
            off_r <= 3'h0;
            size_r <= elm_pkg::ELM_SZ_BYTE;
            addr_r <= 32'h0;
            be_r <= elm_pkg::ELM_BE_RST;
            wdata_r <= elm_pkg::ELM_DATA_RST;
            wr_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= elm_pkg::ELM_DATA_RST;
        end
        else
        begin
            state_r <= state_nxt;
            mode_r <= mode_nxt;
            off_r <= off_nxt;
            size_r <= size_nxt;
            addr_r <= addr_nxt;
            be_r <= be_nxt;
            wdata_r <= wdata_nxt;
            wr_r <= wr_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // R07: lane usage on 64-bit port
    assign bus.req = (state_r == ELM_REQ);
    assign bus.wr = wr_r;
    assign bus.addr = addr_r;
    assign bus.be = be_r;
    assign bus.wdata = wdata_r;
    assign bus.big = mode_r;
    // core handshake
    assign core_ack = (state_r == ELM_IDLE) && core_req;
    assign core_rvalid = rvalid_r;
    assign core_rdata = rdata_r;
endmodule
`default_nettype wire

// *** hdl/elm_target.sv ***
// elm_target: interconnect end with a 32-bit word target behind it
// assumes: system endianness given by a static input; single clock
`timescale 1ns/1ns
`default_nettype none
module elm_target (
    input wire logic clk,
    input wire logic rstn,
    input wire logic sys_big,
    elm_bus_if.targ bus,
    output logic word_req,
    output logic word_wr,
    output logic [31:0] word_addr,
    output logic [3:0] word_be,
    output logic [31:0] word_wdata,
    input wire logic [31:0] word_rdata
);
    logic rv_r, rv_nxt; // read answer pending
    logic [63:0] rd_r, rd_nxt; // read data on lanes
    logic [31:0] wa_r, wa_nxt;
    logic [3:0] wbe_r, wbe_nxt;
    logic [31:0] wd_r, wd_nxt;
    logic wrq_r, wrq_nxt, wwr_r, wwr_nxt;
    logic hi_half; // lanes 63:32 used
    logic odd_word; // word index odd
    logic both_half; // dword: both word halves enabled
    logic beat_r, beat_nxt; // first word of a dword already sent
    logic lst_r, lst_nxt; // word request is the last of its access

    // undo word order of the access to find the word index
    always_comb
    begin
        // R10: honour endianness of access
        both_half = (|bus.be[7:4]) && (|bus.be[3:0]);
        // a dword goes out as low lanes first, then high lanes
        hi_half = both_half ? beat_r : |bus.be[7:4];
        // R12: endian aware bit 2
        odd_word = hi_half ^ bus.big;
    end

    // converter next values
    always_comb
    begin
        rv_nxt = 1'b0;
        rd_nxt = rd_r;
        wrq_nxt = 1'b0;
        wwr_nxt = wwr_r;
        wa_nxt = wa_r;
        wbe_nxt = wbe_r;
        wd_nxt = wd_r;
        beat_nxt = 1'b0;
        lst_nxt = lst_r;
        if (bus.req)
        begin
            // R11: word address uses access order bus.big, not sys_big
            wrq_nxt = 1'b1;
            wwr_nxt = bus.wr;
            wa_nxt = {bus.addr[31:3], odd_word, 2'h0};
            wbe_nxt = hi_half ? bus.be[7:4] : bus.be[3:0];
            wd_nxt = hi_half ? bus.wdata[63:32] : bus.wdata[31:0];
            // dword: hold the request one more cycle for the second word
            beat_nxt = both_half && !beat_r;
            lst_nxt = !both_half || beat_r;
        end
        if (wrq_r && !wwr_r)
        begin
            // place word back by bit 2 and sys_big: the lanes it was asked on only when sys_big equals the access big
            rv_nxt = lst_r;
            if (wa_r[elm_pkg::ELM_WSEL_BIT] ^ sys_big)
            begin
                rd_nxt[63:32] = word_rdata;
            end
            else
            begin
                rd_nxt[31:0] = word_rdata;
            end
        end
    end

    // converter registers
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            rv_r <= 1'b0;
            rd_r <= elm_pkg::ELM_DATA_RST;
            wrq_r <= 1'b0;
            wwr_r <= 1'b0;
            wa_r <= 32'h0;
            wbe_r <= 4'h0;
            wd_r <= 32'h0;
            beat_r <= 1'b0;
            lst_r <= 1'b0;
        end
        else
        begin
            rv_r <= rv_nxt;
            rd_r <= rd_nxt;
            wrq_r <= wrq_nxt;
            wwr_r <= wwr_nxt;
            wa_r <= wa_nxt;
            wbe_r <= wbe_nxt;
            wd_r <= wd_nxt;
            beat_r <= beat_nxt;
            lst_r <= lst_nxt;
        end
    end

    // one word taken at once, a dword on its second cycle
    assign bus.gnt = bus.req && (!both_half || beat_r);
    assign bus.rvalid = rv_r;
    assign bus.rdata = rd_r;
    assign word_req = wrq_r;
    assign word_wr = wwr_r;
    assign word_addr = wa_r;
    assign word_be = wbe_r;
    assign word_wdata = wd_r;
endmodule
`default_nettype wire

// *** tb/elm_assertions.sv ***
// elm_assertions: link checks between mapper and target
// assumes: link signals as inputs, one clock
`timescale 1ns/1ns
`default_nettype none
module elm_assertions (
    input wire logic clk,
    input wire logic rstn,
    input wire logic req,
    input wire logic gnt,
    input wire logic wr,
    input wire logic [7:0] be,
    input wire logic big,
    input wire logic rvalid
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rstn);
    a_lanes_used: assert property (req |-> be != 8'h00)
        else $error("request with no lanes");
    a_half_pairs: assert property (
        req && $countones(be) == 2 |-> be inside {8'h03, 8'h0c, 8'h30, 8'hc0})
        else $error("half lanes split");
    a_word_half: assert property (
        req && $countones(be) == 4 |-> be inside {8'h0f, 8'hf0})
        else $error("word lanes split");
    a_read_answer: assert property (req && gnt && !wr |-> ##2 rvalid)
        else $error("read not answered");
    a_rvalid_cause: assert property (rvalid |-> $past(req && !wr, 2))
        else $error("answer without read");
    a_rvalid_single: assert property (rvalid |=> !rvalid)
        else $error("answer too long");
    a_mode_held: assert property (req && !wr |=> $stable(big) [*3])
        else $error("mode moved in flight");
    a_write_silent: assert property (req && wr |-> ##2 !rvalid)
        else $error("write answered");
    // main traffic kinds
    c_read_little: cover property (req && !wr && !big);
    c_read_big: cover property (req && !wr && big);
    c_write_big: cover property (req && wr && big);
    c_dword: cover property (req && be == 8'hff);
endmodule
`default_nettype wire

// *** tb/endian_lane_mapper_64bit_port_test.sv ***
// endian_lane_mapper_64bit_port_test: both ends joined by the link
// assumes: word memory modelled here behind the target
`timescale 1ns/1ns
`default_nettype none
module endian_lane_mapper_64bit_port_test;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic mode = 1'b0; // 1: big order
    logic req = 1'b0;
    logic wr = 1'b0;
    elm_pkg::elm_size_t sz = elm_pkg::ELM_SZ_BYTE;
    logic [31:0] adr = 32'h0;
    logic [63:0] wd = 64'h0;
    logic ack, rv, w_req, w_wr;
    logic [63:0] rd;
    logic [31:0] w_adr, w_wd, w_rd;
    logic [3:0] w_be;
    logic [31:0] mem [16]; // word_array
    logic [31:0] ref_mem [16]; // expected word_array
    int fail_count = 0;
    int compares = 0;
    int cyc = 0;
    elm_bus_if bus ();
    elm_mapper u_elm_mapper (.clk(clk), .rstn(rstn), .big_mode(mode),
        .core_req(req), .core_wr(wr), .core_size(sz), .core_addr(adr),
        .core_wdata(wd), .core_ack(ack), .core_rvalid(rv),
        .core_rdata(rd), .bus(bus));
    elm_target u_elm_target (.clk(clk), .rstn(rstn), .sys_big(mode),
        .bus(bus), .word_req(w_req), .word_wr(w_wr), .word_addr(w_adr),
        .word_be(w_be), .word_wdata(w_wd), .word_rdata(w_rd));
    elm_assertions u_elm_assertions (.clk(clk), .rstn(rstn),
        .req(bus.req), .gnt(bus.gnt), .wr(bus.wr), .be(bus.be),
        .big(bus.big), .rvalid(bus.rvalid));
    always #50 clk = ~clk;
    assign w_rd = mem[w_adr[5:2]];
    // word memory write with lane enables
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            fail_count++;
            close_out();
        end
        for (int b = 0; b < 4; b++)
            if (w_req && w_wr && w_be[b])
                mem[w_adr[5:2]][8*b +: 8] <= w_wd[8*b +: 8];
    end
    task automatic close_out();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(logic [63:0] got, logic [63:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // bit offset of byte s within its word
    function automatic int ln(int s, logic b);
        return 8 * (b ? 3 - s % 4 : s % 4);
    endfunction
    function automatic logic [63:0] ev(int a, int n, logic b);
        logic [63:0] v;
        v = 64'h0;
        for (int k = 0; k < n; k++)
            v[8*(b ? n-1-k : k) +: 8] = ref_mem[(a+k)/4][ln(a+k, b) +: 8];
        return v;
    endfunction
    // one core access, held until taken
    task automatic acc(logic w, int a, int k, logic [63:0] d,
                       output logic [63:0] q);
        int t;
        @(negedge clk);
        req = 1'b1;
        wr = w;
        adr = a;
        wd = d;
        sz = elm_pkg::elm_size_t'(k[1:0]);
        t = 0;
        #10;
        while (ack !== 1'b1 && t < 20)
        begin
            @(negedge clk);
            #10;
            t++;
        end
        @(negedge clk);
        req = 1'b0;
        t = 0;
        while ((w ? bus.gnt : rv) !== 1'b1 && t < 20)
        begin
            @(negedge clk);
            t++;
        end
        q = rd;
    endtask
    task automatic set_mode(logic b);
        @(negedge clk);
        mode = b;
    endtask
    task automatic rchk(int a, int k);
        logic [63:0] q;
        acc(1'b0, a, k, 64'h0, q);
        chk(q, ev(a, 1 << k, mode));
    endtask
    task automatic t_lanes();
        for (int m = 0; m < 2; m++)
        begin
            set_mode(m[0]);
            for (int a = 0; a < 8; a++)
                rchk(a, 0);
            for (int a = 0; a < 8; a += 2)
                rchk(a, 1);
            rchk(0, 3);
            rchk(8, 3);
        end
    endtask
    task automatic t_swap();
        logic [63:0] q0;
        logic [63:0] q1;
        for (int i = 4; i < 8; i++)
        begin
            set_mode(1'b0);
            acc(1'b0, i, 0, 64'h0, q0);
            set_mode(1'b1);
            acc(1'b0, i ^ 3, 0, 64'h0, q1);
            chk(q1, q0);
            chk(q0, 64'(i));
        end
    endtask
    task automatic t_words();
        logic [63:0] q0;
        logic [63:0] q1;
        for (int a = 0; a < 16; a += 4)
        begin
            set_mode(1'b0);
            acc(1'b0, a, 2, 64'h0, q0);
            set_mode(1'b1);
            acc(1'b0, a, 2, 64'h0, q1);
            chk(q1, q0);
            chk(q0, 64'(ref_mem[a/4]));
        end
    endtask
    task automatic t_writes();
        logic [63:0] q;
        for (int m = 0; m < 2; m++)
        begin
            set_mode(m[0]);
            for (int k = 0; k < 4; k++)
            begin
                acc(1'b1, 32*m + 8*k, k, 64'hf1e2d3c4b5a69788, q);
                for (int j = 0; j < (1 << k); j++)
                    ref_mem[(32*m+8*k+j)/4][ln(32*m+8*k+j, mode) +: 8] =
                        8'(64'hf1e2d3c4b5a69788 >> 8*(m ? (1<<k)-1-j : j));
                rchk(32*m + 8*k, k);
            end
        end
        for (int i = 0; i < 16; i++)
            chk(64'(mem[i]), 64'(ref_mem[i]));
    endtask
    initial
    begin
        for (int i = 0; i < 16; i++)
        begin
            mem[i] = 32'h03020100 + 32'h04040404 * i;
            ref_mem[i] = mem[i];
        end
        repeat (6) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        t_lanes();
        t_swap();
        t_words();
        t_writes();
        close_out();
    end
endmodule
`default_nettype wire
